// *** logic/async_rx_pkg.sv ***
// Summary of operation
// - receiver enable bit switches receiver on/off
// - holding register buffers character during next frame
// - sampler decides bits, resyncs on edges
// - stop bit completes frame, loads holding register
// - noise, framing and parity flags update only at transfer
// - full holding register blocks transfer, sets overrun
// - overrun frame sets no other error flag
// - status read arms, data read clears flags
// - receive interrupt follows full flag when enabled and not asleep
// - idle line is ones run of frame size
// - idle detection always on, type selectable
// - short idle counts every ones run
// - long idle counts only after stop bit
// - idle interrupt when enabled and not asleep, read sequence clears
// - idle rearms only after a received frame
// - sleep suppresses flags; hardware or software clears
// - wake mode selects idle or address mark
// - idle wake clears sleep, next frame normal
// - address mark frame wakes and is received
// - loopback feeds transmitter, transmit pin idles high
// - sampling tick runs sixteen per bit
// - parity odd select, top data bit checked
// - frame length select picks 10 or 11 bits
package async_rx_pkg;
  localparam int ADDR_W = 8;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] DIV_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] DATA_OFS = 8'h0C;
  // serial_control_register_one fields
  localparam int CTRL_W = 10;
  localparam int RECEIVER_ENABLE_BIT = 0;
  localparam int RECEIVE_INTERRUPT_ENABLE = 1;
  localparam int IDLE_INTERRUPT_ENABLE = 2;
  localparam int IDLE_TYPE_SELECT = 3;
  localparam int WAKE_MODE_SELECT = 4;
  localparam int RECEIVER_SLEEP_BIT = 5;
  localparam int INTERNAL_FEEDBACK_ENABLE = 6;
  localparam int PARITY_ODD_SELECT = 7;
  localparam int PARITY_ENABLE = 8;
  localparam int FRAME_LENGTH_SELECT = 9;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 10'h000;
  localparam logic [15:0] DIV_RESET = 16'h0000;
  // serial_status_register fields
  localparam int STS_RECEIVE_FULL = 0;
  localparam int STS_IDLE = 1;
  localparam int STS_OVERRUN = 2;
  localparam int STS_NOISE = 3;
  localparam int STS_FRAMING = 4;
  localparam int STS_PARITY = 5;
  localparam int STS_ACTIVE = 6;
  localparam int STS_LINE = 7;
  // sampling: sixteen ticks per bit, three votes around the centre
  localparam logic [3:0] TICK_LAST = 4'hF;
  localparam logic [3:0] SAMPLE_A = 4'h7;
  localparam logic [3:0] SAMPLE_B = 4'h8;
  localparam logic [3:0] SAMPLE_C = 4'h9;
  // frame shapes
  localparam logic [3:0] DATA_BITS_SHORT = 4'h8;
  localparam logic [3:0] DATA_BITS_LONG = 4'h9;
  localparam logic [3:0] FRAME_BITS_SHORT = 4'hA;
  localparam logic [3:0] FRAME_BITS_LONG = 4'hB;
  typedef enum logic [1:0] {
    ST_HUNT = 2'b00,
    ST_DATA = 2'b01,
    ST_STOP = 2'b10
  } rx_state_t;
endpackage

// *** logic/async_serial_receiver.sv ***
// Decided for this implementation: the address map and the APB register port.
module async_serial_receiver #(
  parameter int DIV_W = 13
) (
  // system
  input wire logic clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [async_rx_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial line
  input wire logic rx_pin,
  input wire logic tx_from_transmitter,
  output logic tx_pin,
  // interrupt request
  output logic rx_irq
);
  import async_rx_pkg::*;

  if (DIV_W < 4 || DIV_W > 16) begin : g_bad_div_w
    $error("DIV_W must lie between 4 and 16");
  end

  // register file state
  logic [CTRL_W-1:0] ctrl_q, ctrl_d;
  logic [DIV_W-1:0] div_q, div_d;
  logic [31:0] prdata_q, prdata_d;
  logic arm_q, arm_d;

  // receiver state
  rx_state_t st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [8:0] shift_q, shift_d;
  logic frame_noise_q, frame_noise_d;
  logic [3:0] ones_q, ones_d;
  logic long_arm_q, long_arm_d;
  logic idle_seen_q, idle_seen_d;
  logic idle_allow_q, idle_allow_d;
  logic [8:0] hold_q, hold_d;
  logic full_q, full_d;
  logic idle_q, idle_d;
  logic overrun_q, overrun_d;
  logic noise_q, noise_d;
  logic parity_err_q, parity_err_d;
  logic framing_q, framing_d;
  logic sleep_q, sleep_d;

  // decoded controls
  logic rx_en, rx_irq_en, idle_irq_en, long_idle, wake_mark, loop_en;
  logic odd_parity, parity_on, long_frame;
  logic [3:0] data_bits, frame_bits;
  logic [8:0] data_mask;
  logic top_bit, parity_sum;

  // bus decode
  logic setup, access, addr_ok, wr_ctrl, wr_div, rd_status, rd_data;
  logic [31:0] status_word, ctrl_word, div_word, data_word;
  logic [31:0] lane_mask;

  // sampler link
  logic tick, bit_strobe, bit_value, bit_noise, rx_line;

  // receiver working values
  logic ones_next_ok;
  logic idle_event;
  logic deliver;

  assign rx_en = ctrl_q[RECEIVER_ENABLE_BIT];
  assign rx_irq_en = ctrl_q[RECEIVE_INTERRUPT_ENABLE];
  assign idle_irq_en = ctrl_q[IDLE_INTERRUPT_ENABLE];
  assign long_idle = ctrl_q[IDLE_TYPE_SELECT];
  assign wake_mark = ctrl_q[WAKE_MODE_SELECT];
  assign loop_en = ctrl_q[INTERNAL_FEEDBACK_ENABLE];
  assign odd_parity = ctrl_q[PARITY_ODD_SELECT];
  assign parity_on = ctrl_q[PARITY_ENABLE];
  assign long_frame = ctrl_q[FRAME_LENGTH_SELECT];

  assign data_bits = long_frame ? DATA_BITS_LONG : DATA_BITS_SHORT;
  assign frame_bits = long_frame ? FRAME_BITS_LONG : FRAME_BITS_SHORT;
  assign data_mask = long_frame ? 9'h1FF : 9'h0FF;
  assign top_bit = long_frame ? shift_q[8] : shift_q[7];
  assign parity_sum = ^(shift_q & data_mask);

  // loopback: transmitter drives the receiver, the pin rests at mark
  assign rx_line = loop_en ? tx_from_transmitter : rx_pin;
  assign tx_pin = loop_en ? 1'b1 : tx_from_transmitter;

  sample_tick_gen #(
    .DIV_W(DIV_W)
  ) u_tick (
    .clk(clk),
    .rst(rst),
    .divisor(div_q),
    .tick(tick)
  );

  bit_sampler u_sampler (
    .clk(clk),
    .rst(rst),
    .enable(rx_en),
    .hunting(st_q == ST_HUNT),
    .tick(tick),
    .line(rx_line),
    .bit_strobe(bit_strobe),
    .bit_value(bit_value),
    .bit_noise(bit_noise)
  );

  // zero wait states: every access phase completes at once
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign addr_ok = (paddr == CTRL_OFS) || (paddr == DIV_OFS) ||
                   (paddr == STATUS_OFS) || (paddr == DATA_OFS);
  assign pready = access;
  assign pslverr = access && !addr_ok;
  assign wr_ctrl = access && pwrite && (paddr == CTRL_OFS);
  assign wr_div = access && pwrite && (paddr == DIV_OFS);
  assign rd_status = access && !pwrite && (paddr == STATUS_OFS);
  assign rd_data = access && !pwrite && (paddr == DATA_OFS);
  assign lane_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[STS_RECEIVE_FULL] = full_q;
    status_word[STS_IDLE] = idle_q;
    status_word[STS_OVERRUN] = overrun_q;
    status_word[STS_NOISE] = noise_q;
    status_word[STS_FRAMING] = framing_q;
    status_word[STS_PARITY] = parity_err_q;
    status_word[STS_ACTIVE] = (st_q != ST_HUNT);
    status_word[STS_LINE] = rx_line;
    ctrl_word = 32'h0000_0000;
    ctrl_word[CTRL_W-1:0] = ctrl_q;
    ctrl_word[RECEIVER_SLEEP_BIT] = sleep_q;
    div_word = 32'h0000_0000;
    div_word[DIV_W-1:0] = div_q;
    data_word = {23'h00_0000, hold_q};
  end

  // register group: control, divisor, read data, clear arming
  always_comb begin
    ctrl_d = ctrl_q;
    div_d = div_q;
    prdata_d = prdata_q;
    arm_d = arm_q;
    if (wr_ctrl) begin
      ctrl_d = (ctrl_q & ~lane_mask[CTRL_W-1:0]) | (pwdata[CTRL_W-1:0] & lane_mask[CTRL_W-1:0]);
    end
    if (wr_div) begin
      div_d = (div_q & ~lane_mask[DIV_W-1:0]) | (pwdata[DIV_W-1:0] & lane_mask[DIV_W-1:0]);
    end
    if (setup) begin
      unique case (paddr)
        CTRL_OFS: prdata_d = ctrl_word;
        DIV_OFS: prdata_d = div_word;
        STATUS_OFS: prdata_d = status_word;
        DATA_OFS: prdata_d = data_word;
        default: prdata_d = 32'h0000_0000;
      endcase
    end
    // a status read arms, the data read that follows consumes the arming
    if (rd_data) begin
      arm_d = 1'b0;
    end
    if (rd_status) begin
      arm_d = 1'b1;
    end
  end

  // receiver group
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    shift_d = shift_q;
    frame_noise_d = frame_noise_q;
    ones_d = ones_q;
    long_arm_d = long_arm_q;
    idle_seen_d = idle_seen_q;
    idle_allow_d = idle_allow_q;
    hold_d = hold_q;
    full_d = full_q;
    idle_d = idle_q;
    overrun_d = overrun_q;
    noise_d = noise_q;
    parity_err_d = parity_err_q;
    framing_d = framing_q;
    sleep_d = sleep_q;
    ones_next_ok = 1'b0;
    idle_event = 1'b0;
    deliver = 1'b0;
    // clear first so that an event in the same cycle still lands
    if (rd_data && arm_q) begin
      full_d = 1'b0;
      idle_d = 1'b0;
      overrun_d = 1'b0;
      noise_d = 1'b0;
      parity_err_d = 1'b0;
      framing_d = 1'b0;
    end
    if (!rx_en) begin
      // line ignored, holding register and flags kept as they are
      st_d = ST_HUNT;
      cnt_d = 4'h0;
      ones_d = 4'h0;
      idle_seen_d = 1'b0;
    end else if (bit_strobe) begin
      // idle counting runs beside the frame machine in every state
      if (!bit_value) begin
        ones_d = 4'h0;
        long_arm_d = 1'b0;
        idle_seen_d = 1'b0;
      end else if (!long_idle || long_arm_q) begin
        ones_next_ok = 1'b1;
        if (ones_q != frame_bits) begin
          ones_d = ones_q + 4'h1;
        end
      end
      if (ones_next_ok && (ones_d == frame_bits) && !idle_seen_q) begin
        idle_seen_d = 1'b1;
        idle_event = 1'b1;
      end
      if (idle_event) begin
        if (sleep_q && !wake_mark) begin
          sleep_d = 1'b0;
        end else if (!sleep_q && idle_allow_q) begin
          idle_d = 1'b1;
          idle_allow_d = 1'b0;
        end
      end
      unique case (st_q)
        ST_HUNT: begin
          if (!bit_value) begin
            st_d = ST_DATA;
            cnt_d = 4'h0;
            shift_d = 9'h000;
            frame_noise_d = bit_noise;
          end
        end
        ST_DATA: begin
          shift_d[cnt_q] = bit_value;
          frame_noise_d = frame_noise_q | bit_noise;
          cnt_d = cnt_q + 4'h1;
          if (cnt_q == data_bits - 4'h1) begin
            st_d = ST_STOP;
          end
        end
        ST_STOP: begin
          st_d = ST_HUNT;
          // long idle counts only the ones that follow a good stop bit
          long_arm_d = bit_value;
          deliver = 1'b1;
          if (sleep_q) begin
            if (wake_mark && top_bit) begin
              sleep_d = 1'b0;
            end else begin
              deliver = 1'b0;
            end
          end
          if (deliver) begin
            if (full_d) begin
              // held character kept, new one dropped, no other error flagged
              overrun_d = 1'b1;
            end else begin
              hold_d = shift_q & data_mask;
              full_d = 1'b1;
              idle_allow_d = 1'b1;
              noise_d = noise_d | frame_noise_q | bit_noise;
              framing_d = framing_d | !bit_value;
              parity_err_d = parity_err_d | (parity_on && (parity_sum != odd_parity));
            end
          end
        end
        default: begin
          st_d = ST_HUNT;
        end
      endcase
    end
    // software may set or clear sleep; its write wins over a wake-up
    if (wr_ctrl && pstrb[0]) begin
      sleep_d = pwdata[RECEIVER_SLEEP_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q <= CTRL_RESET;
      div_q <= DIV_RESET[DIV_W-1:0];
      prdata_q <= 32'h0000_0000;
      arm_q <= 1'b0;
      st_q <= ST_HUNT;
      cnt_q <= 4'h0;
      shift_q <= 9'h000;
      frame_noise_q <= 1'b0;
      ones_q <= 4'h0;
      long_arm_q <= 1'b1;
      idle_seen_q <= 1'b0;
      idle_allow_q <= 1'b1;
      hold_q <= 9'h000;
      full_q <= 1'b0;
      idle_q <= 1'b0;
      overrun_q <= 1'b0;
      noise_q <= 1'b0;
      parity_err_q <= 1'b0;
      framing_q <= 1'b0;
      sleep_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      div_q <= div_d;
      prdata_q <= prdata_d;
      arm_q <= arm_d;
      st_q <= st_d;
      cnt_q <= cnt_d;
      shift_q <= shift_d;
      frame_noise_q <= frame_noise_d;
      ones_q <= ones_d;
      long_arm_q <= long_arm_d;
      idle_seen_q <= idle_seen_d;
      idle_allow_q <= idle_allow_d;
      hold_q <= hold_d;
      full_q <= full_d;
      idle_q <= idle_d;
      overrun_q <= overrun_d;
      noise_q <= noise_d;
      parity_err_q <= parity_err_d;
      framing_q <= framing_d;
      sleep_q <= sleep_d;
    end
  end

  assign prdata = prdata_q;
  // level request; error flags share the receive request
  assign rx_irq = !sleep_q && ((rx_irq_en && full_q) || (idle_irq_en && idle_q));
endmodule

// *** logic/bit_sampler.sv ***
module bit_sampler (
  // system
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic enable,
  input wire logic hunting,
  input wire logic tick,
  input wire logic line,
  // decided bit
  output logic bit_strobe,
  output logic bit_value,
  output logic bit_noise
);
  import async_rx_pkg::*;
  logic [3:0] phase_q, phase_d;
  logic prev_q, prev_d, vote_a_q, vote_a_d, vote_b_q, vote_b_d;
  logic strobe_q, strobe_d, value_q, value_d, noise_q, noise_d;
  logic in_window;
  assign in_window = (phase_q >= SAMPLE_A) && (phase_q <= SAMPLE_C);
  always_comb begin
    phase_d = phase_q;
    prev_d = prev_q;
    vote_a_d = vote_a_q;
    vote_b_d = vote_b_q;
    strobe_d = 1'b0;
    value_d = value_q;
    noise_d = noise_q;
    if (!enable) begin
      phase_d = '0;
      prev_d = 1'b1;
    end else if (tick) begin
      prev_d = line;
      // inside a frame an edge in the vote window is a glitch, not a boundary
      if ((line != prev_q) && (hunting || !in_window)) begin
        phase_d = '0;
      end else if (phase_q == TICK_LAST) begin
        phase_d = '0;
      end else begin
        phase_d = phase_q + 4'h1;
      end
      if (phase_q == SAMPLE_A) begin
        vote_a_d = line;
      end
      if (phase_q == SAMPLE_B) begin
        vote_b_d = line;
      end
      if (phase_q == SAMPLE_C) begin
        strobe_d = 1'b1;
        value_d = (vote_a_q & vote_b_q) | (vote_a_q & line) | (vote_b_q & line);
        noise_d = !((vote_a_q == vote_b_q) && (vote_b_q == line));
      end
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      phase_q <= 4'h0;
      prev_q <= 1'b1;
      vote_a_q <= 1'b1;
      vote_b_q <= 1'b1;
      strobe_q <= 1'b0;
      value_q <= 1'b1;
      noise_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      prev_q <= prev_d;
      vote_a_q <= vote_a_d;
      vote_b_q <= vote_b_d;
      strobe_q <= strobe_d;
      value_q <= value_d;
      noise_q <= noise_d;
    end
  end
  assign bit_strobe = strobe_q;
  assign bit_value = value_q;
  assign bit_noise = noise_q;
endmodule

// *** logic/sample_tick_gen.sv ***
module sample_tick_gen #(
  parameter int DIV_W = 13
) (
  // system
  input wire logic clk,
  input wire logic rst,
  // divisor in system clocks per tick, zero stops the tick
  input wire logic [DIV_W-1:0] divisor,
  output logic tick
);
  logic [DIV_W-1:0] cnt_q, cnt_d;
  logic tick_q, tick_d;
  always_comb begin
    cnt_d = cnt_q + 1'b1;
    tick_d = 1'b0;
    if (divisor == '0) begin
      cnt_d = '0;
    end else if (cnt_q >= divisor - 1'b1) begin
      cnt_d = '0;
      tick_d = 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end
  assign tick = tick_q;
endmodule

// *** testbench/async_rx_props.sv ***
module async_rx_props (
  // system
  input wire logic clk,
  input wire logic rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [async_rx_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // line
  input wire logic rx_pin,
  input wire logic tx_from_transmitter,
  input wire logic tx_pin,
  input wire logic rx_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  import async_rx_pkg::*;
  // software copy of control; sleep may read stale-high after a hardware wake
  logic [CTRL_W-1:0] ctrl_q;
  logic [CTRL_W-1:0] ctrl_d;
  logic used_q;
  logic used_d;
  logic acc;
  logic rs;
  logic rdat;
  assign acc = psel && penable;
  assign rs = acc && !pwrite && paddr == STATUS_OFS;
  assign rdat = acc && !pwrite && paddr == DATA_OFS;
  always_comb begin
    ctrl_d = ctrl_q;
    if (acc && pwrite && paddr == CTRL_OFS && pstrb[0]) ctrl_d[7:0] = pwdata[7:0];
    if (acc && pwrite && paddr == CTRL_OFS && pstrb[1]) ctrl_d[9:8] = pwdata[9:8];
    used_d = used_q || ctrl_d[RECEIVER_ENABLE_BIT];
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q <= CTRL_RESET;
      used_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      used_q <= used_d;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  property p_loop;
    tx_pin == (ctrl_q[INTERNAL_FEEDBACK_ENABLE] || tx_from_transmitter);
  endproperty
  a_loop: assert property (p_loop) else $error("tx pin wrong");
  property p_irq_en;
    rx_irq |-> ctrl_q[RECEIVE_INTERRUPT_ENABLE] || ctrl_q[IDLE_INTERRUPT_ENABLE];
  endproperty
  a_irq_en: assert property (p_irq_en) else $error("irq unenabled");
  property p_irq_full;
    rs && prdata[STS_RECEIVE_FULL] && ctrl_q[1] && !ctrl_q[5] |-> rx_irq;
  endproperty
  a_irq_full: assert property (p_irq_full) else $error("no full irq");
  property p_irq_idle;
    rs && prdata[STS_IDLE] && ctrl_q[2] && !ctrl_q[5] |-> rx_irq;
  endproperty
  a_irq_idle: assert property (p_irq_idle) else $error("no idle irq");
  property p_ovr;
    rs && prdata[STS_OVERRUN] |-> prdata[STS_RECEIVE_FULL];
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun not full");
  property p_err;
    rs && (prdata[STS_NOISE] || prdata[STS_FRAMING] || prdata[STS_PARITY])
      |-> prdata[STS_RECEIVE_FULL];
  endproperty
  a_err: assert property (p_err) else $error("error without transfer");
  property p_width;
    rdat |-> prdata[31:9] == 23'h0 && (ctrl_q[FRAME_LENGTH_SELECT] || !prdata[8]);
  endproperty
  a_width: assert property (p_width) else $error("data too wide");
  property p_off;
    rs && !used_q |-> prdata[5:2] == 4'h0 && !prdata[STS_RECEIVE_FULL];
  endproperty
  a_off: assert property (p_off) else $error("flags while off");
endmodule
bind async_serial_receiver async_rx_props props (.clk(clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_pin(rx_pin),
  .tx_from_transmitter(tx_from_transmitter), .tx_pin(tx_pin), .rx_irq(rx_irq));

// *** testbench/serial_line_model.sv ***
module serial_line_model (
  // system
  input wire logic clk,
  // line of the remote sender, marks high between frames
  output logic line
);
  timeunit 1ns;
  timeprecision 1ps;
  initial line = 1'b1;
  task automatic put_bit(input logic v, input int clks);
    line <= v;
    repeat (clks) @(posedge clk);
  endtask
  // start, nb data bits lsb first, stop; a low stop makes a framing fault
  task automatic send(input logic [8:0] d, input int nb, input logic stop, input int clks);
    put_bit(1'b0, clks);
    for (int k = 0; k < nb; k++) put_bit(d[k], clks);
    put_bit(stop, clks);
    // back to mark after a faulty stop
    if (!stop) line <= 1'b1;
  endtask
endmodule

// *** testbench/test_async_serial_receiver.sv ***
module test_async_serial_receiver;
  timeunit 1ns;
  timeprecision 1ps;
  import async_rx_pkg::*;
  // divisor two: sixteen ticks of two clocks per bit
  localparam int BIT = 32;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic rx_pin;
  logic tx_src;
  logic tx_pin;
  logic rx_irq;
  logic [31:0] rd;
  logic [31:0] r;
  logic err;
  int miscompares = 0;
  int tests_run = 0;
  int seed = 73700;
  int i;
  async_serial_receiver DUT (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_pin(rx_pin), .tx_from_transmitter(tx_src),
    .tx_pin(tx_pin), .rx_irq(rx_irq));
  serial_line_model far_rx (.clk(clk), .line(rx_pin));
  serial_line_model far_tx (.clk(clk), .line(tx_src));
  initial forever #5 clk = ~clk;
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic ck(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v,
      input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 16) begin
      @(posedge clk);
      n++;
    end
    if (n == 16) begin
      miscompares++;
      print_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] m,
      input logic [31:0] e);
    apb(1'b0, a, 32'h0, 4'hF);
    ck(nm, e, rd & m);
  endtask
  task automatic bits(input int n);
    repeat (n * BIT) @(posedge clk);
  endtask
  // top data bit chosen to give the wanted parity, or the wrong one when bad is set
  function automatic logic [8:0] with_parity(input logic [8:0] d, input logic nine,
      input logic odd, input logic bad);
    logic [8:0] w;
    w = d;
    if (nine) begin
      w[8] = ^d[7:0] ^ odd ^ bad;
    end else begin
      w[8] = 1'b0;
      w[7] = ^d[6:0] ^ odd ^ bad;
    end
    return w;
  endfunction
  initial begin
    repeat (100000) @(posedge clk);
    miscompares++;
    print_verdict();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rc("ctrl", CTRL_OFS, 32'hFFFF_FFFF, 32'h0);
    rc("bad addr", 8'h10, 32'hFFFF_FFFF, 32'h0);
    ck("slverr", 32'h1, {31'h0, err});
    apb(1'b1, DIV_OFS, 32'h2, 4'hF);
    rc("div", DIV_OFS, 32'hFFFF_FFFF, 32'h2);
    far_rx.send(9'h0A5, 8, 1'b1, BIT);
    rc("st off", STATUS_OFS, 32'h3D, 32'h0);
    apb(1'b1, CTRL_OFS, 32'h3, 4'hF);
    for (i = 0; i < 3; i++) begin
      r = $random(seed);
      far_rx.send(r[8:0], 8, 1'b1, BIT);
      fork
        far_rx.send(r[24:16], 8, 1'b1, BIT);
        rc("held", DATA_OFS, 32'hFFFF_FFFF, {24'h0, r[7:0]});
      join
      ck("irq", 32'h1, {31'h0, rx_irq});
      rc("st", STATUS_OFS, 32'h3D, 32'h1);
      rc("dat", DATA_OFS, 32'hFFFF_FFFF, {24'h0, r[23:16]});
      rc("clr", STATUS_OFS, 32'h3D, 32'h0);
    end
    r = $random(seed);
    far_rx.send(r[8:0], 8, 1'b1, BIT);
    far_rx.send(r[24:16], 8, 1'b0, BIT);
    rc("ovr", STATUS_OFS, 32'h3D, 32'h5);
    rc("kept", DATA_OFS, 32'hFFFF_FFFF, {24'h0, r[7:0]});
    far_rx.send(r[8:0], 8, 1'b0, BIT);
    rc("frm", STATUS_OFS, 32'h3D, 32'h11);
    rc("dat", DATA_OFS, 32'hFFFF_FFFF, {24'h0, r[7:0]});
    for (i = 0; i < 8; i++) begin
      apb(1'b1, CTRL_OFS, {22'h0, i[2], 1'b1, i[1], 7'h01}, 4'hF);
      r = $random(seed);
      r[8:0] = with_parity(r[8:0], i[2], i[1], i[0]);
      far_rx.send(r[8:0], i[2] ? 9 : 8, 1'b1, BIT);
      rc("par", STATUS_OFS, 32'h3D, {26'h0, i[0], 5'h01});
      rc("dat", DATA_OFS, 32'hFFFF_FFFF, {23'h0, r[8:0]});
    end
    for (i = 0; i < 2; i++) begin
      apb(1'b1, CTRL_OFS, {28'h0, i[0], 3'h5}, 4'hF);
      far_rx.send(9'h0FF, 8, 1'b1, BIT);
      bits(2);
      ck("irq idle", {31'h0, ~i[0]}, {31'h0, rx_irq});
      rc("idle early", STATUS_OFS, 32'h2, {30'h0, ~i[0], 1'b0});
      bits(10);
      rc("idle", STATUS_OFS, 32'h2, 32'h2);
      rc("dat", DATA_OFS, 32'hFFFF_FFFF, 32'hFF);
      bits(12);
      rc("no reidle", STATUS_OFS, 32'h3, 32'h0);
      ck("irq off", 32'h0, {31'h0, rx_irq});
    end
    apb(1'b1, CTRL_OFS, 32'h233, 4'hF);
    far_rx.send(9'h055, 9, 1'b1, BIT);
    ck("irq sleep", 32'h0, {31'h0, rx_irq});
    rc("st sleep", STATUS_OFS, 32'h3D, 32'h0);
    far_rx.send(9'h155, 9, 1'b1, BIT);
    rc("woke", CTRL_OFS, 32'h20, 32'h0);
    rc("st", STATUS_OFS, 32'h3D, 32'h1);
    rc("addr", DATA_OFS, 32'hFFFF_FFFF, 32'h155);
    apb(1'b1, CTRL_OFS, 32'h0, 4'h2);
    rc("lanes", CTRL_OFS, 32'hFFFF_FFFF, 32'h13);
    apb(1'b1, CTRL_OFS, 32'h23, 4'hF);
    bits(12);
    r = $random(seed);
    far_rx.send(r[8:0], 8, 1'b1, BIT);
    rc("woke", CTRL_OFS, 32'h20, 32'h0);
    // status first, so the data read below frees the holding register again
    rc("st wake", STATUS_OFS, 32'h3D, 32'h1);
    rc("dat", DATA_OFS, 32'hFFFF_FFFF, {24'h0, r[7:0]});
    // transmitter side is taken as enabled before loopback
    apb(1'b1, CTRL_OFS, 32'h43, 4'hF);
    r = $random(seed);
    fork
      far_tx.send(r[8:0], 8, 1'b1, BIT);
      far_rx.send(~r[8:0], 8, 1'b1, BIT);
      begin
        repeat (2) @(posedge clk);
        ck("tx idle", 32'h1, {31'h0, tx_pin});
      end
    join
    rc("st loop", STATUS_OFS, 32'h3D, 32'h1);
    rc("loop", DATA_OFS, 32'hFFFF_FFFF, {24'h0, r[7:0]});
    apb(1'b1, CTRL_OFS, 32'h0, 4'hF);
    far_rx.send(9'h03C, 8, 1'b1, BIT);
    rc("st off", STATUS_OFS, 32'h1, 32'h0);
    print_verdict();
  end
endmodule
